/* File: rtl/rqpc_consts.vh */
`ifndef RQPC_CONSTS_VH
`define RQPC_CONSTS_VH

// Power modes
`define RQPC_MODE_STANDBY     2'b00
`define RQPC_MODE_PARTIAL     2'b01
`define RQPC_MODE_ACTIVE      2'b10

// Integrator thresholds and rates
`define RQPC_INT_QUALIFY      6'd48
`define RQPC_INT_DEQUALIFY    6'd32
`define RQPC_INT_MAX          6'd63
`define RQPC_UP_RATE_HZ       800
`define RQPC_DOWN_RATE_HZ     400

// System clock and derived tick periods
`define RQPC_CLK_HZ           25000000
`define RQPC_CRYSTAL_HZ       3579000
`define RQPC_RESONATOR_HZ     455000
`define RQPC_UP_DIV_XTAL      ((`RQPC_CLK_HZ / `RQPC_UP_RATE_HZ))
`define RQPC_UP_DIV_RES       ((`RQPC_CLK_HZ / `RQPC_UP_RATE_HZ) * `RQPC_CRYSTAL_HZ / `RQPC_RESONATOR_HZ / 8)

// Carrier timing
`define RQPC_DROPOUT_MS       8
`define RQPC_ACQUIRE_MS       14
`define RQPC_DROPOUT_CYC      (`RQPC_DROPOUT_MS * (`RQPC_CLK_HZ / 1000))
`define RQPC_ACQUIRE_CYC      (`RQPC_ACQUIRE_MS * (`RQPC_CLK_HZ / 1000))

// Validation: a run of one more than this many mark bits; the alternating pattern is not checked
`define RQPC_BAUD             1200
`define RQPC_BIT_CYC          (`RQPC_CLK_HZ / `RQPC_BAUD)
`define RQPC_MARK_BITS        8'd60

`endif

/* File: rtl/rqpc_fifo.v */
`default_nettype none
module rqpc_fifo #(
    parameter WIDTH = 1,
    parameter DEPTH = 8,
    parameter AW    = 3
) (
    // Clock and reset
    input  wire             clock,
    input  wire             rstn,
    // Fill side
    input  wire             in_valid,
    output wire             in_ready,
    input  wire [WIDTH-1:0] in_data,
    // Drain side
    output wire             out_valid,
    input  wire             out_ready,
    output reg  [WIDTH-1:0] out_data
);
    reg [WIDTH-1:0] mem [0:DEPTH-1];
    reg [AW-1:0]    wr_q;
    reg [AW-1:0]    rd_q;
    reg [AW:0]      cnt_q;
    wire            push;
    wire            pop;

    assign in_ready  = (cnt_q != DEPTH[AW:0]);
    assign out_valid = (cnt_q != {(AW+1){1'b0}});
    assign push      = in_valid & in_ready;
    assign pop       = out_valid & out_ready;

    always @* begin
        out_data = mem[rd_q];
    end

    always @(posedge clock) begin
        if (push) begin
            mem[wr_q] <= in_data;
        end
    end

    always @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            wr_q  <= {AW{1'b0}};
            rd_q  <= {AW{1'b0}};
            cnt_q <= {(AW+1){1'b0}};
        end else begin
            if (push) begin
                wr_q <= (wr_q == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : wr_q + 1'b1;
            end
            if (pop) begin
                rd_q <= (rd_q == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : rd_q + 1'b1;
            end
            if (push && !pop) begin
                cnt_q <= cnt_q + 1'b1;
            end else if (pop && !push) begin
                cnt_q <= cnt_q - 1'b1;
            end
        end
    end
endmodule
`default_nettype wire

/* File: rtl/rqpc_top.v */
// Summary of operation
// - power_request_n low puts the block in active mode regardless of ring_time_hold.
// - power_request_n and ring_time_hold both high with no latched line energy give standby, oscillator off.
// - ring_time_hold low with power_request_n high powers only ring validation.
// - Line energy enables the oscillator and the ring qualification sampling.
// - clock_select high means crystal timing, low means resonator timing.
// - ring_valid_n open-drain, low while the ring stays qualified.
// - carrier_valid_n open-drain, low while a valid carrier is present.
// - carrier_valid_n rides through carrier dropouts up to 8 ms.
// - raw_data_out carries demodulated bits while carrier_valid_n is low.
// - raw_data_out held high whenever carrier_valid_n is not low.
// - validated_data_out carries data only after validation, no preamble, else high.
// - Data is asynchronous serial at 1200 bps, mark one, space zero.
// - Ring integrator counts up at 800 Hz while ring_qualify_in is high.
// - Ring integrator counts down at 400 Hz while ring_qualify_in is low.
// - Ring is qualified when the integrator reaches 48.
// - Qualified ring is released only when the count falls back to 32, or at once when the block drops to standby.
// - Qualify takes at least about 60 ms, dequalify about 40 ms.
// - In active mode ring_time_hold is ignored.
// - Host releases power_request_n after the message; block returns to standby.
// - Line energy with ring_time_hold high starts partial power-up and ring analysis.
// - carrier_valid_n goes low about 14 ms after carrier appears.
`include "rqpc_consts.vh"
`default_nettype none
module rqpc_top #(
    parameter UP_DIV_XTAL  = `RQPC_UP_DIV_XTAL,
    parameter UP_DIV_RES   = `RQPC_UP_DIV_RES,
    parameter DROPOUT_CYC  = `RQPC_DROPOUT_CYC,
    parameter ACQUIRE_CYC  = `RQPC_ACQUIRE_CYC,
    parameter BIT_CYC      = `RQPC_BIT_CYC,
    parameter FIFO_DEPTH   = 8
) (
    // Clock and reset
    input  wire       clock,
    input  wire       rstn,
    // Power control pins
    input  wire       power_request_n,
    input  wire       ring_time_hold,
    input  wire       clock_select,
    // Line comparators
    input  wire       line_energy_in,
    input  wire       ring_qualify_in,
    // Demodulator front end
    input  wire       carrier_present,
    input  wire       demod_bit,
    // Status outputs
    output reg  [1:0] power_mode,
    output wire       osc_enable,
    // Ring valid open-drain pin
    output wire       ring_valid_n_out,
    output wire       ring_valid_n_oe_n,
    // Carrier valid open-drain pin
    output wire       carrier_valid_n_out,
    output wire       carrier_valid_n_oe_n,
    // Data outputs with drain handshake
    output reg        raw_data_out,
    output reg        validated_data_out,
    input  wire       data_ready
);
    ////////////////////////////////////////////////////////////////////////
    // Power sequencing
    reg        energy_q;
    wire       analysis_on;
    wire       active;
    wire       carrier_ok;

    assign active      = !power_request_n;
    // Line energy latches until it ends while power_request_n and ring_time_hold are both high
    assign analysis_on = active || !ring_time_hold || energy_q;
    assign osc_enable  = analysis_on;

    always @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            energy_q   <= 1'b0;
            power_mode <= `RQPC_MODE_STANDBY;
        end else begin
            if (line_energy_in) begin
                energy_q <= 1'b1;
            end else if (ring_time_hold && power_request_n) begin
                energy_q <= 1'b0;
            end
            if (active) begin
                power_mode <= `RQPC_MODE_ACTIVE;
            end else if (!ring_time_hold || energy_q) begin
                power_mode <= `RQPC_MODE_PARTIAL;
            end else begin
                power_mode <= `RQPC_MODE_STANDBY;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Tick divider: 800 Hz up tick, every second one is the 400 Hz tick
    reg  [31:0] div_q;
    reg         half_q;
    wire [31:0] div_top;
    wire        tick_up;
    wire        tick_down;

    // Resonator setting scales only the ring tick period, by the clock ratio divided by 8
    assign div_top   = clock_select ? UP_DIV_XTAL : UP_DIV_RES;
    assign tick_up   = analysis_on && (div_q == div_top - 1);
    assign tick_down = tick_up && half_q;

    always @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            div_q  <= 32'h0;
            half_q <= 1'b0;
        end else if (!analysis_on) begin
            div_q  <= 32'h0;
            half_q <= 1'b0;
        end else if (tick_up) begin
            div_q  <= 32'h0;
            half_q <= !half_q;
        end else begin
            div_q <= div_q + 32'h1;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Ring integrator with hysteresis
    reg [5:0] ring_cnt_q;
    reg       ring_ok_q;

    always @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            ring_cnt_q <= 6'h00;
            ring_ok_q  <= 1'b0;
        end else if (!analysis_on) begin
            ring_cnt_q <= 6'h00;
            ring_ok_q  <= 1'b0;
        end else begin
            if (ring_qualify_in && tick_up && ring_cnt_q != `RQPC_INT_MAX) begin
                ring_cnt_q <= ring_cnt_q + 6'h01;
            end else if (!ring_qualify_in && tick_down && ring_cnt_q != 6'h00) begin
                ring_cnt_q <= ring_cnt_q - 6'h01;
            end
            // 48 up ticks at 800 Hz is 60 ms, 16 down ticks at 400 Hz is 40 ms
            if (ring_cnt_q >= `RQPC_INT_QUALIFY) begin
                ring_ok_q <= 1'b1;
            end else if (ring_cnt_q <= `RQPC_INT_DEQUALIFY) begin
                ring_ok_q <= 1'b0;
            end
        end
    end

    assign ring_valid_n_out  = 1'b0;
    assign ring_valid_n_oe_n = !ring_ok_q;

    ////////////////////////////////////////////////////////////////////////
    // Carrier detect with acquisition delay and dropout hold
    reg [31:0] acq_q;
    reg [31:0] hold_q;
    reg        carrier_q;

    always @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            acq_q     <= 32'h0;
            hold_q    <= 32'h0;
            carrier_q <= 1'b0;
        end else if (!active) begin
            acq_q     <= 32'h0;
            hold_q    <= 32'h0;
            carrier_q <= 1'b0;
        end else if (carrier_present) begin
            hold_q <= 32'h0;
            if (!carrier_q) begin
                if (acq_q == ACQUIRE_CYC - 1) begin
                    carrier_q <= 1'b1;
                end else begin
                    acq_q <= acq_q + 32'h1;
                end
            end
        end else begin
            acq_q <= 32'h0;
            if (carrier_q) begin
                if (hold_q == DROPOUT_CYC - 1) begin
                    carrier_q <= 1'b0;
                    hold_q    <= 32'h0;
                end else begin
                    hold_q <= hold_q + 32'h1;
                end
            end
        end
    end

    assign carrier_ok           = carrier_q;
    assign carrier_valid_n_out  = 1'b0;
    assign carrier_valid_n_oe_n = !carrier_q;

    ////////////////////////////////////////////////////////////////////////
    // Bit sampling at 1200 bps and preamble validation
    reg  [31:0] bit_q;
    reg         prev_bit_q;
    reg  [7:0]  marks_q;
    reg         valid_q;
    wire        bit_tick;

    assign bit_tick = carrier_ok && (bit_q == BIT_CYC - 1);

    always @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            bit_q      <= 32'h0;
            prev_bit_q <= 1'b1;
            marks_q    <= 8'h00;
            valid_q    <= 1'b0;
        end else if (!carrier_ok) begin
            bit_q   <= 32'h0;
            marks_q <= 8'h00;
            valid_q <= 1'b0;
        end else begin
            bit_q <= bit_tick ? 32'h0 : bit_q + 32'h1;
            if (bit_tick) begin
                prev_bit_q <= demod_bit;
                // A run of 61 mark bits since the last space passes validation; the alternating pattern is not checked
                if (!demod_bit) begin
                    marks_q <= 8'h00;
                end else if (marks_q != `RQPC_MARK_BITS) begin
                    marks_q <= marks_q + 8'h01;
                end else begin
                    valid_q <= 1'b1;
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Output buffer: raw and cooked bit pairs; drain stall backs up here
    wire       fifo_in_ready;
    wire       fifo_out_valid;
    wire [1:0] fifo_out_data;
    reg        drop_q;

    rqpc_fifo #(
        .WIDTH (2),
        .DEPTH (FIFO_DEPTH),
        .AW    (3)
    ) u_fifo (
        .clock     (clock),
        .rstn      (rstn),
        .in_valid  (bit_tick),
        .in_ready  (fifo_in_ready),
        .in_data   ({demod_bit, valid_q ? demod_bit : 1'b1}),
        .out_valid (fifo_out_valid),
        .out_ready (data_ready),
        .out_data  (fifo_out_data)
    );

    // Bits are real time; a full buffer only records that one was lost
    always @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            drop_q             <= 1'b0;
            raw_data_out       <= 1'b1;
            validated_data_out <= 1'b1;
        end else begin
            drop_q <= bit_tick && !fifo_in_ready;
            if (!carrier_ok) begin
                raw_data_out       <= 1'b1;
                validated_data_out <= 1'b1;
            end else if (fifo_out_valid && data_ready) begin
                raw_data_out       <= fifo_out_data[1];
                validated_data_out <= fifo_out_data[0];
            end
        end
    end
endmodule
`default_nettype wire

/* File: tb/rqpc_line_model.sv */
`default_nettype none
module rqpc_line_model (
    // Device pins
    input  wire logic ring_valid_n_out,
    input  wire logic ring_valid_n_oe_n,
    input  wire logic carrier_valid_n_out,
    input  wire logic carrier_valid_n_oe_n,
    // Controller side
    input  wire logic host_auto,
    input  wire logic host_req_n,
    // Resolved wires
    output wire logic ring_pin,
    output wire logic carrier_pin,
    output wire logic power_request_n
);
    timeunit 1ns;
    timeprecision 1ps;
    // Pull-ups hold released open-drain pins high
    assign ring_pin = ring_valid_n_oe_n ? 1'h1 : ring_valid_n_out;
    assign carrier_pin = carrier_valid_n_oe_n ? 1'h1 : carrier_valid_n_out;
    // Wired-OR feedback or controller; the controller releases the request after the message
    assign power_request_n = host_auto ? (ring_pin & carrier_pin) : host_req_n;
endmodule
`default_nettype wire

/* File: tb/rqpc_top_sva.sv */
`default_nettype none
`include "rqpc_consts.vh"
module rqpc_top_sva #(
    parameter int ACQUIRE_CYC = 30,
    parameter int DROPOUT_CYC = 20
) (
    // Clock, reset, inputs
    input wire logic       clock,
    input wire logic       rstn,
    input wire logic       power_request_n,
    input wire logic       ring_time_hold,
    input wire logic       clock_select,
    input wire logic       line_energy_in,
    input wire logic       ring_qualify_in,
    input wire logic       carrier_present,
    input wire logic       demod_bit,
    input wire logic       data_ready,
    // Outputs
    input wire logic [1:0] power_mode,
    input wire logic       osc_enable,
    input wire logic       ring_valid_n_out,
    input wire logic       ring_valid_n_oe_n,
    input wire logic       carrier_valid_n_out,
    input wire logic       carrier_valid_n_oe_n,
    input wire logic       raw_data_out,
    input wire logic       validated_data_out
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [31:0] pres_q;
    logic [31:0] abs_q;
    default clocking cb @(posedge clock); endclocking
    default disable iff (!rstn);
    ////////////////////////////////////////////////////////////
    // Saturating run lengths of carrier presence and absence
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            pres_q <= 32'h0;
            abs_q <= 32'h0;
        end else begin
            pres_q <= !carrier_present ? 32'h0 : (pres_q < ACQUIRE_CYC + 4) ? pres_q + 32'h1 : pres_q;
            abs_q <= carrier_present ? 32'h0 : (abs_q < DROPOUT_CYC + 4) ? abs_q + 32'h1 : abs_q;
        end
    end
    ////////////////////////////////////////////////////////////
    active_mode_a: assert property (!power_request_n |=> power_mode == `RQPC_MODE_ACTIVE)
        else $error("active mode not entered");
    // Latched energy needs one edge to clear before the mode can drop to standby
    standby_mode_a: assert property (
        power_request_n && ring_time_hold && !line_energy_in ##1
        power_request_n && ring_time_hold && !line_energy_in |=> power_mode == `RQPC_MODE_STANDBY)
        else $error("standby not entered");
    partial_mode_a: assert property (
        power_request_n && !ring_time_hold |-> osc_enable ##1 power_mode == `RQPC_MODE_PARTIAL)
        else $error("partial power-up missing");
    ring_qualify_a: assert property (
        $fell(ring_valid_n_oe_n) |-> $past(ring_qualify_in) || $past(ring_qualify_in, 2))
        else $error("ring qualified without input");
    ring_hold_a: assert property (
        $fell(ring_valid_n_oe_n) |=> (!ring_valid_n_oe_n || power_mode == `RQPC_MODE_STANDBY) [*8])
        else $error("ring released too soon");
    drain_wire_a: assert property (!ring_valid_n_out && !carrier_valid_n_out)
        else $error("open-drain level not low");
    acq_early_a: assert property ($fell(carrier_valid_n_oe_n) |-> pres_q >= ACQUIRE_CYC - 1)
        else $error("carrier valid too early");
    acq_late_a: assert property (
        pres_q == ACQUIRE_CYC + 3 && !power_request_n |-> !carrier_valid_n_oe_n)
        else $error("carrier valid too late");
    dropout_hold_a: assert property (
        $rose(carrier_valid_n_oe_n) |-> abs_q >= DROPOUT_CYC - 1 || $past(power_request_n))
        else $error("carrier released inside dropout");
    dropout_end_a: assert property (abs_q == DROPOUT_CYC + 3 |-> carrier_valid_n_oe_n)
        else $error("carrier not released");
    data_idle_a: assert property (
        carrier_valid_n_oe_n && $past(carrier_valid_n_oe_n) && $past(carrier_valid_n_oe_n, 2)
        |-> raw_data_out && validated_data_out)
        else $error("data outputs not idle high");
    ring_cov: cover property ($fell(ring_valid_n_oe_n));
    carrier_cov: cover property ($fell(carrier_valid_n_oe_n));
    valid_data_cov: cover property (!validated_data_out);
    partial_cov: cover property (power_mode == `RQPC_MODE_PARTIAL);
endmodule
bind rqpc_top rqpc_top_sva #(.ACQUIRE_CYC(ACQUIRE_CYC), .DROPOUT_CYC(DROPOUT_CYC)) u_rqpc_top_sva (
    .clock(clock), .rstn(rstn), .power_request_n(power_request_n), .ring_time_hold(ring_time_hold),
    .clock_select(clock_select), .line_energy_in(line_energy_in), .ring_qualify_in(ring_qualify_in),
    .carrier_present(carrier_present), .demod_bit(demod_bit), .data_ready(data_ready),
    .power_mode(power_mode), .osc_enable(osc_enable), .ring_valid_n_out(ring_valid_n_out),
    .ring_valid_n_oe_n(ring_valid_n_oe_n), .carrier_valid_n_out(carrier_valid_n_out),
    .carrier_valid_n_oe_n(carrier_valid_n_oe_n), .raw_data_out(raw_data_out),
    .validated_data_out(validated_data_out));
`default_nettype wire

/* File: tb/rqpc_top_bench.sv */
`default_nettype none
`include "rqpc_consts.vh"
module rqpc_top_bench;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int XD = 4, RD = 5, ACQ = 30, DRP = 20, BIT = 8;
    // Control word bits: auto, request, hold, energy, qualify, select, carrier, bit, ready
    localparam int AUTO = 0, REQ = 1, CP = 6, DB = 7, DR = 8;
    // Mode table: {hold, request, energy, expected mode}
    localparam logic [4:0] MTBL [6] = '{5'h18, 5'h09, 5'h12, 5'h02, 5'h18, 5'h1D};
    logic            clock;
    logic            rstn;
    logic [8:0]      ctl;
    int              failures;
    int              tests_run;
    wire logic [1:0] power_mode;
    wire logic [3:0] obs;
    wire logic       power_request_n, osc_enable, ring_pin, carrier_pin, raw_data_out, validated_data_out;
    wire logic       ring_valid_n_out, ring_valid_n_oe_n, carrier_valid_n_out, carrier_valid_n_oe_n;
    assign obs = {validated_data_out, raw_data_out, carrier_pin, ring_pin};
    rqpc_line_model u_rqpc_line_model (.ring_valid_n_out(ring_valid_n_out), .ring_valid_n_oe_n(ring_valid_n_oe_n),
        .carrier_valid_n_out(carrier_valid_n_out), .carrier_valid_n_oe_n(carrier_valid_n_oe_n),
        .host_auto(ctl[AUTO]), .host_req_n(ctl[REQ]), .ring_pin(ring_pin), .carrier_pin(carrier_pin),
        .power_request_n(power_request_n));
    rqpc_top #(.UP_DIV_XTAL(XD), .UP_DIV_RES(RD), .DROPOUT_CYC(DRP), .ACQUIRE_CYC(ACQ), .BIT_CYC(BIT),
        .FIFO_DEPTH(8)) u_rqpc_top (.clock(clock), .rstn(rstn), .power_request_n(power_request_n),
        .ring_time_hold(ctl[2]), .line_energy_in(ctl[3]), .ring_qualify_in(ctl[4]), .clock_select(ctl[5]),
        .carrier_present(ctl[CP]), .demod_bit(ctl[DB]), .data_ready(ctl[DR]), .power_mode(power_mode),
        .osc_enable(osc_enable), .ring_valid_n_out(ring_valid_n_out), .ring_valid_n_oe_n(ring_valid_n_oe_n),
        .carrier_valid_n_out(carrier_valid_n_out), .carrier_valid_n_oe_n(carrier_valid_n_oe_n),
        .raw_data_out(raw_data_out), .validated_data_out(validated_data_out));
    ////////////////////////////////////////////////////////////
    task automatic check(input logic [1:0] got, input logic [1:0] exp);
        tests_run++;
        if (got !== exp) begin
            failures++;
            $display("[FAIL] %0t ns: got %0d, expected %0d", $time, got, exp);
        end
    endtask
    task automatic stop_test();
        $display("checks %0d, mismatches %0d", tests_run, failures);
        if (failures == 0 && tests_run > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    task automatic wait_cyc(input int n);
        repeat (n) @(negedge clock);
    endtask
    // Bounded poll of one observed output; running out ends the run
    task automatic wait_for(input int s, input logic v, input int n);
        for (int i = 0; i < n && obs[s] !== v; i++) @(negedge clock);
        if (obs[s] !== v) begin
            failures++;
            $display("[FAIL] %0t ns: wait on output %0d ran out", $time, s);
            stop_test();
        end
    endtask
    task automatic bits(input logic v, input int n);
        ctl[DB] = v;
        wait_cyc(n * BIT);
    endtask
    task automatic done(input string name);
        $display("%0t ns: test %s done", $time, name);
    endtask
    ////////////////////////////////////////////////////////////
    initial begin
        clock = 1'h0;
        forever #20 clock = ~clock;
    end
    initial begin
        failures = 0;
        tests_run = 0;
        ctl = 9'h106;
        rstn = 1'h0;
        wait_cyc(12);
        rstn = 1'h1;
        wait_cyc(2);
        for (int k = 0; k < 6; k++) begin
            ctl[3:1] = {MTBL[k][2], MTBL[k][4], MTBL[k][3]};
            wait_cyc(3);
            check(power_mode, MTBL[k][1:0]);
            check(osc_enable, MTBL[k][1:0] != 2'h0);
        end
        done("modes");
        ctl[5:2] = 4'hE; // crystal, energy, above threshold, hold low
        wait_cyc(40 * XD);
        check(ring_pin, 1'h1);
        wait_for(0, 1'h0, 30 * XD);
        ctl[4] = 1'h0;
        wait_cyc(20 * XD);
        check(ring_pin, 1'h0);
        wait_for(0, 1'h1, 28 * XD);
        wait_cyc(80 * XD); // Integrator drains to zero and must stop there
        ctl[5:4] = 2'h1;
        wait_cyc(40 * RD);
        check(ring_pin, 1'h1);
        wait_for(0, 1'h0, 30 * RD);
        wait_cyc(80 * RD); // Hold above threshold until the count tops out
        ctl[5:4] = 2'h2;
        wait_cyc(50 * XD);
        check(ring_pin, 1'h0);
        wait_for(0, 1'h1, 30 * XD);
        done("ring");
        ctl[4] = 1'h1; // Ring back above threshold so the wired-OR can request power
        ctl[AUTO] = 1'h1;
        wait_for(0, 1'h0, 70 * XD);
        wait_cyc(3);
        check(power_mode, `RQPC_MODE_ACTIVE);
        ctl[4:2] = 3'h1;
        wait_for(0, 1'h1, 50 * XD);
        wait_cyc(3);
        check(power_mode, `RQPC_MODE_STANDBY);
        ctl[AUTO] = 1'h0;
        done("auto");
        ctl[REQ] = 1'h0;
        wait_cyc(20);
        ctl[CP] = 1'h1;
        wait_cyc(ACQ - 5);
        check(carrier_pin, 1'h1);
        check(raw_data_out, 1'h1);
        wait_for(1, 1'h0, 10);
        bits(1'h0, 6);
        check(raw_data_out, 1'h0);
        check(validated_data_out, 1'h1);
        for (int k = 0; k < 20; k++) bits(k[0], 1);
        check(validated_data_out, 1'h1);
        bits(1'h1, 62);
        bits(1'h0, 6);
        check(validated_data_out, 1'h0);
        ctl[CP] = 1'h0;
        wait_cyc(DRP / 2);
        check(carrier_pin, 1'h0);
        ctl[CP] = 1'h1;
        bits(1'h1, 2);
        ctl[DR] = 1'h0;
        bits(1'h0, 12); // Stalled drain: the buffer fills, later bits are dropped
        ctl[DR] = 1'h1;
        ctl[DB] = 1'h1;
        wait_cyc(2);
        check(raw_data_out, 1'h0);
        bits(1'h1, 3);
        check(raw_data_out, 1'h1);
        ctl[CP] = 1'h0;
        wait_cyc(DRP - 4);
        check(carrier_pin, 1'h0);
        wait_for(1, 1'h1, 10);
        wait_cyc(3);
        check(raw_data_out, 1'h1);
        check(validated_data_out, 1'h1);
        ctl[REQ] = 1'h1;
        wait_cyc(3);
        check(power_mode, `RQPC_MODE_STANDBY);
        done("carrier");
        stop_test();
    end
endmodule
`default_nettype wire
